// [verilog/tif_axi_regs.sv]
`timescale 1ns/100ps
// Overview of operation
// R1: The arithmetic error trap status flag sits at bit 4 of the trap register.
// R2: A math error trap sets that flag to 1; it reads 0 when no such trap happened.
// R3: An address error trap sets bit 3 of the trap register.
// R4: A stack error trap sets bit 2 of the trap register.
// R5: An oscillator failure trap sets bit 1 of the trap register.
// R6: Bit 0 of the trap register, bits 13 to 5 of the control register and bit 15 of flag register 0 read 0.
// R7: Control bit 15 set to 1 selects the alternate vector table, 0 the standard one.
// R8: Control bit 14 is read-only and reads 1 while an interrupt-disable instruction runs.
// R9: Each of the five external inputs is caught on its falling edge when its polarity bit is 1, else rising; only input 0 reaches a flag.
// R10: DMA channel 1 completion sets flag bit 14 and DMA channel 0 completion sets flag bit 4.
// R11: An ADC one conversion completion sets flag bit 13.
// R12: UART one transmit sets flag bit 12 and receive sets flag bit 11.
// R13: SPI one event sets flag bit 10 and SPI one fault sets flag bit 9.
// R14: Timers 3, 2 and 1 set flag bits 8, 7 and 3.
// R15: Compare 2 and capture 2 set bits 6 and 5; compare 1, capture 1 and external 0 set bits 2, 1 and 0.
// R16: All implemented writable bits of the control register and flag register 0 reset to 0 and are read/write.
// R17: Software clears a flag by writing 0 to it and the flag stays set until then.
module tif_axi_regs
   import tif_pkg::*;
(
   input wire logic CLK_SYS_I,
   input wire logic RST_B_I,
   input wire logic [7:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic [7:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   input wire logic [3:0] TRAP_EVENT_I,
   input wire logic IRQ_DISABLE_ACTIVE_ACTIVE_I,
   input wire logic [14:0] PERIPH_REQ_I,
   input wire logic [4:0] EXT_IRQ_PIN_I,
   output logic ALT_VECTOR_TABLE_SEL_O,
   output logic IRQ_O
);

   typedef struct packed {
      logic [REG_W-1:0] trap;
      logic [REG_W-1:0] trap_mask;
      logic [REG_W-1:0] vec;
      logic [REG_W-1:0] flag0;
      logic [REG_W-1:0] flag0_mask;
      logic [3:0] trap_sync1;
      logic [3:0] trap_sync2;
      logic [14:0] req_sync1;
      logic [14:0] req_sync2;
      logic [14:0] req_prev;
      logic irq_disable_active_sync1;
      logic irq_disable_active_sync2;
      logic aw_full;
      logic [7:0] aw_addr;
      logic w_full;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic irq;
      // Readies are kept in flip-flops so every bus output leaves a register; they rise one cycle after reset.
      logic aw_rdy;
      logic w_rdy;
      logic ar_rdy;
   } tif_regs_s;

   tif_regs_s st;
   tif_regs_s next_st;
   tif_ext_if ext ();

   function automatic logic addr_known(input logic [7:0] a);
      addr_known = (a == ADDR_TRAP_CTL) || (a == ADDR_VEC_EDGE) || (a == ADDR_FLAG0) ||
                   (a == ADDR_FLAG0_MASK) || (a == ADDR_TRAP_MASK);
   endfunction

   function automatic logic [15:0] merge_lanes(input logic [15:0] old, input logic [31:0] d,
                                               input logic [3:0] s);
      merge_lanes = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   tif_edge_det #(
      .N(NUM_EXT)
   ) u_edge (
      .clk_sys_i(CLK_SYS_I),
      .rst_b_i(RST_B_I),
      .ext(ext.det)
   );

   assign ext.pins = EXT_IRQ_PIN_I;
   assign ext.polarity = st.vec[NUM_EXT-1:0]; // see R9

   logic [REG_W-1:0] trap_set;
   logic [REG_W-1:0] flag_set;
   logic [14:0] req_rise;
   logic do_write;
   logic do_read;
   logic [REG_W-1:0] wr_val;
   logic [REG_W-1:0] rd_val;

   always_comb begin
      next_st = st;
      next_st.trap_sync1 = TRAP_EVENT_I;
      next_st.trap_sync2 = st.trap_sync1;
      next_st.req_sync1 = PERIPH_REQ_I;
      next_st.req_sync2 = st.req_sync1;
      next_st.req_prev = st.req_sync2;
      next_st.irq_disable_active_sync1 = IRQ_DISABLE_ACTIVE_ACTIVE_I;
      next_st.irq_disable_active_sync2 = st.irq_disable_active_sync1;

      // Trap inputs are levels; any high cycle latches the sticky bit.
      trap_set = RST_ZERO;
      trap_set[TRAP_ARITH_BIT] = st.trap_sync2[0]; // see R1 // see R2
      trap_set[TRAP_ADDR_BIT] = st.trap_sync2[1]; // see R3
      trap_set[TRAP_STACK_BIT] = st.trap_sync2[2]; // see R4
      trap_set[TRAP_OSC_BIT] = st.trap_sync2[3]; // see R5

      // Peripheral requests are taken on their rising edge so a held request is not re-flagged after a clear.
      req_rise = st.req_sync2 & ~st.req_prev;
      flag_set = RST_ZERO;
      flag_set[FLG_DMA1] = req_rise[14]; // see R10
      flag_set[FLG_ADC1] = req_rise[13]; // see R11
      flag_set[FLG_UTX] = req_rise[12]; // see R12
      flag_set[FLG_URX] = req_rise[11]; // see R12
      flag_set[FLG_SPI] = req_rise[10]; // see R13
      flag_set[FLG_SPIF] = req_rise[9]; // see R13
      flag_set[FLG_T3] = req_rise[8]; // see R14
      flag_set[FLG_T2] = req_rise[7]; // see R14
      flag_set[FLG_OC2] = req_rise[6]; // see R15
      flag_set[FLG_IC2] = req_rise[5]; // see R15
      flag_set[FLG_DMA0] = req_rise[4]; // see R10
      flag_set[FLG_T1] = req_rise[3]; // see R14
      flag_set[FLG_OC1] = req_rise[2]; // see R15
      flag_set[FLG_IC1] = req_rise[1]; // see R15
      flag_set[FLG_EXT0] = req_rise[0] | ext.edge_seen[0]; // see R15 // see R9

      // Write channel: hold address and data until both are in, then answer once.
      if (S_AXI_AWVALID_I && st.aw_rdy) begin
         next_st.aw_full = 1'b1;
         next_st.aw_addr = S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && st.w_rdy) begin
         next_st.w_full = 1'b1;
         next_st.w_data = S_AXI_WDATA_I;
         next_st.w_strb = S_AXI_WSTRB_I;
      end
      do_write = st.aw_full && st.w_full && !st.bvalid;
      wr_val = RST_ZERO;
      if (do_write) begin
         next_st.aw_full = 1'b0;
         next_st.w_full = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = addr_known(st.aw_addr) ? RESP_OKAY : RESP_SLVERR;
         case (st.aw_addr)
            ADDR_TRAP_CTL: begin
               wr_val = merge_lanes(st.trap, st.w_data, st.w_strb);
               next_st.trap = wr_val & TRAP_IMPL_MASK;
            end
            ADDR_VEC_EDGE: begin
               wr_val = merge_lanes(st.vec, st.w_data, st.w_strb);
               next_st.vec = wr_val & VEC_RW_MASK; // see R7 // see R16
            end
            ADDR_FLAG0: begin
               wr_val = merge_lanes(st.flag0, st.w_data, st.w_strb);
               next_st.flag0 = wr_val & FLAG0_IMPL_MASK; // see R16 // see R17
            end
            ADDR_FLAG0_MASK: begin
               wr_val = merge_lanes(st.flag0_mask, st.w_data, st.w_strb);
               next_st.flag0_mask = wr_val & FLAG0_IMPL_MASK;
            end
            ADDR_TRAP_MASK: begin
               wr_val = merge_lanes(st.trap_mask, st.w_data, st.w_strb);
               next_st.trap_mask = wr_val & TRAP_IMPL_MASK;
            end
            default: begin
               wr_val = RST_ZERO;
            end
         endcase
      end
      if (st.bvalid && S_AXI_BREADY_I) begin
         next_st.bvalid = 1'b0;
      end

      // Hardware sets win over a software clear in the same cycle.
      next_st.trap = next_st.trap | trap_set;
      next_st.flag0 = next_st.flag0 | flag_set; // see R17

      // Read channel.
      do_read = S_AXI_ARVALID_I && st.ar_rdy;
      rd_val = RST_ZERO;
      case (S_AXI_ARADDR_I)
         ADDR_TRAP_CTL: rd_val = st.trap & TRAP_IMPL_MASK; // see R6
         ADDR_VEC_EDGE: begin
            rd_val = st.vec & VEC_RW_MASK; // see R6
            rd_val[VEC_IRQ_DISABLE_ACTIVE_BIT] = st.irq_disable_active_sync2; // see R8
         end
         ADDR_FLAG0: rd_val = st.flag0 & FLAG0_IMPL_MASK; // see R6
         ADDR_FLAG0_MASK: rd_val = st.flag0_mask;
         ADDR_TRAP_MASK: rd_val = st.trap_mask;
         default: rd_val = RST_ZERO;
      endcase
      if (do_read) begin
         next_st.rvalid = 1'b1;
         next_st.rdata = {16'h0000, rd_val};
         next_st.rresp = addr_known(S_AXI_ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
      end else if (st.rvalid && S_AXI_RREADY_I) begin
         next_st.rvalid = 1'b0;
      end

      next_st.irq = |((next_st.flag0 & st.flag0_mask) | (next_st.trap & st.trap_mask));
      next_st.aw_rdy = !next_st.aw_full;
      next_st.w_rdy = !next_st.w_full;
      next_st.ar_rdy = !next_st.rvalid;
   end

   always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         st <= '0; // see R16
      end else begin
         st <= next_st;
      end
   end

   assign S_AXI_AWREADY_O = st.aw_rdy;
   assign S_AXI_WREADY_O = st.w_rdy;
   assign S_AXI_BVALID_O = st.bvalid;
   assign S_AXI_BRESP_O = st.bresp;
   assign S_AXI_ARREADY_O = st.ar_rdy;
   assign S_AXI_RVALID_O = st.rvalid;
   assign S_AXI_RDATA_O = st.rdata;
   assign S_AXI_RRESP_O = st.rresp;
   assign ALT_VECTOR_TABLE_SEL_O = st.vec[VEC_ALT_BIT]; // see R7
   assign IRQ_O = st.irq;
endmodule

// [verilog/tif_pkg.sv]
package tif_pkg;
   // Register byte addresses on the bus; no offsets are printed, so these are chosen.
   localparam logic [7:0] ADDR_TRAP_CTL = 8'h00;
   localparam logic [7:0] ADDR_VEC_EDGE = 8'h04;
   localparam logic [7:0] ADDR_FLAG0 = 8'h08;
   localparam logic [7:0] ADDR_FLAG0_MASK = 8'h0c;
   localparam logic [7:0] ADDR_TRAP_MASK = 8'h10;

   localparam int REG_W = 16;
   localparam int NUM_EXT = 5;

   // Trap register field positions.
   localparam int TRAP_ARITH_BIT = 4;
   localparam int TRAP_ADDR_BIT = 3;
   localparam int TRAP_STACK_BIT = 2;
   localparam int TRAP_OSC_BIT = 1;
   localparam logic [15:0] TRAP_IMPL_MASK = 16'h001e;

   // Control register field positions.
   localparam int VEC_ALT_BIT = 15;
   localparam int VEC_IRQ_DISABLE_ACTIVE_BIT = 14;
   localparam logic [15:0] VEC_RW_MASK = 16'h801f;

   // Flag register field positions.
   localparam int FLG_DMA1 = 14;
   localparam int FLG_ADC1 = 13;
   localparam int FLG_UTX = 12;
   localparam int FLG_URX = 11;
   localparam int FLG_SPI = 10;
   localparam int FLG_SPIF = 9;
   localparam int FLG_T3 = 8;
   localparam int FLG_T2 = 7;
   localparam int FLG_OC2 = 6;
   localparam int FLG_IC2 = 5;
   localparam int FLG_DMA0 = 4;
   localparam int FLG_T1 = 3;
   localparam int FLG_OC1 = 2;
   localparam int FLG_IC1 = 1;
   localparam int FLG_EXT0 = 0;
   localparam logic [15:0] FLAG0_IMPL_MASK = 16'h7fff;

   localparam logic [15:0] RST_ZERO = 16'h0000;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// [verilog/tif_ext_if.sv]
`timescale 1ns/100ps
interface tif_ext_if;
   logic [4:0] pins;
   logic [4:0] polarity;
   logic [4:0] edge_seen;
   modport ctrl (output pins, output polarity, input edge_seen);
   modport det (input pins, input polarity, output edge_seen);
endinterface

// [verilog/tif_edge_det.sv]
`timescale 1ns/100ps
module tif_edge_det
   import tif_pkg::*;
#(
   parameter int N = NUM_EXT
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   tif_ext_if.det ext
);
   typedef struct packed {
      logic [N-1:0] sync1;
      logic [N-1:0] sync2;
      logic [N-1:0] prev;
      logic [N-1:0] hit;
   } tif_det_s;

   tif_det_s st;
   tif_det_s next_st;

   always_comb begin
      next_st = st;
      next_st.sync1 = ext.pins;
      next_st.sync2 = st.sync1;
      next_st.prev = st.sync2;
      for (int i = 0; i < N; i++) begin
         // Polarity 1 picks the falling edge, 0 the rising edge.
         next_st.hit[i] = ext.polarity[i] ? (st.prev[i] & ~st.sync2[i])
                                          : (~st.prev[i] & st.sync2[i]); // see R9
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign ext.edge_seen = st.hit;
endmodule

// [tb/tif_axi_regs_assertions.sv]
`timescale 1ns/100ps
module tif_axi_regs_assertions
   import tif_pkg::*;
(
   input wire logic CLK_SYS_I,
   input wire logic RST_B_I,
   input wire logic [7:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   input wire logic S_AXI_ARREADY_O,
   input wire logic [31:0] S_AXI_RDATA_O,
   input wire logic [1:0] S_AXI_RRESP_O,
   input wire logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   input wire logic S_AXI_AWREADY_O,
   input wire logic S_AXI_WREADY_O,
   input wire logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic ALT_VECTOR_TABLE_SEL_O,
   input wire logic IRQ_O
);
   logic [7:0] ar_q;
   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (!RST_B_I);
   always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         ar_q <= 8'h00;
      end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
         ar_q <= S_AXI_ARADDR_I;
      end
   end
   a_upper_half_zero: assert property (S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:16] == 16'h0000)
      else $error("upper read half not zero");
   a_trap_unused_zero: assert property (S_AXI_RVALID_O && ar_q == ADDR_TRAP_CTL |->
      (S_AXI_RDATA_O[15:0] & ~TRAP_IMPL_MASK) == 16'h0000) else $error("trap spare bits set");
   a_ctrl_read_fields: assert property (S_AXI_RVALID_O && ar_q == ADDR_VEC_EDGE |->
      S_AXI_RDATA_O[13:5] == 9'h000 && S_AXI_RDATA_O[15] == ALT_VECTOR_TABLE_SEL_O)
      else $error("control read fields wrong");
   a_flag_top_zero: assert property (S_AXI_RVALID_O && ar_q == ADDR_FLAG0 |-> !S_AXI_RDATA_O[15])
      else $error("flag bit 15 set");
   a_unmapped_error: assert property (S_AXI_RVALID_O && ar_q > ADDR_TRAP_MASK |->
      S_AXI_RRESP_O == RESP_SLVERR && S_AXI_RDATA_O == 32'h0) else $error("unmapped read not refused");
   a_read_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
      else $error("read answer late");
   a_read_holds: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
      else $error("read answer dropped");
   a_write_resp_holds: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O)
      else $error("write answer dropped");
   a_write_busy: assert property ($rose(S_AXI_BVALID_O) |-> $past(!S_AXI_AWREADY_O) && $past(!S_AXI_WREADY_O))
      else $error("write answered before both channels were held");
   a_vec_sel_by_write: assert property ($changed(ALT_VECTOR_TABLE_SEL_O) |->
      S_AXI_BVALID_O || $past(S_AXI_BVALID_O)) else $error("table select moved without write");
   c_refused: cover property (S_AXI_RVALID_O && S_AXI_RRESP_O == RESP_SLVERR);
   c_irq: cover property ($rose(IRQ_O));
   c_alt: cover property ($rose(ALT_VECTOR_TABLE_SEL_O));
endmodule
bind tif_axi_regs tif_axi_regs_assertions u_chk (.*);

// [tb/tif_periph_model.sv]
`timescale 1ns/100ps
module tif_periph_model (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic [23:0] fire_i,
   output logic [3:0] trap_o,
   output logic [14:0] req_o,
   output logic [4:0] pin_o
);
   // Requests last six cycles so the two-stage synchroniser cannot miss them.
   logic [18:0][2:0] cnt = '0;
   logic [18:0] line;
   logic [4:0] pins = 5'h00;
   always_comb begin
      for (int i = 0; i < 19; i++) begin
         line[i] = cnt[i] != 3'h0;
      end
   end
   assign {trap_o, req_o} = line;
   assign pin_o = pins;
   always @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         cnt <= '0;
         pins <= 5'h00;
      end else begin
         pins <= pins ^ fire_i[23:19];
         for (int i = 0; i < 19; i++) begin
            cnt[i] <= fire_i[i] ? 3'h6 : (line[i] ? cnt[i] - 3'h1 : 3'h0);
         end
      end
   end
endmodule

// [tb/trap_and_irq_flag_regs_tb.sv]
`timescale 1ns/100ps
module trap_and_irq_flag_regs_tb;
   import tif_pkg::*;
   logic CLK_SYS_I = 0, RST_B_I = 0, IRQ_DISABLE_ACTIVE_ACTIVE_I = 0, S_AXI_BREADY_I = 1, S_AXI_RREADY_I = 1;
   logic S_AXI_AWVALID_I = 0, S_AXI_WVALID_I = 0, S_AXI_ARVALID_I = 0, S_AXI_AWREADY_O, S_AXI_WREADY_O;
   logic S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O, ALT_VECTOR_TABLE_SEL_O, IRQ_O;
   logic [7:0] S_AXI_AWADDR_I = 8'h00, S_AXI_ARADDR_I = 8'h00;
   logic [31:0] S_AXI_WDATA_I = 32'h0, S_AXI_RDATA_O, seed = 32'h5b726b44;
   logic [3:0] S_AXI_WSTRB_I = 4'hf, TRAP_EVENT_I;
   logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O;
   logic [14:0] PERIPH_REQ_I;
   logic [4:0] EXT_IRQ_PIN_I;
   logic [23:0] fire = '0;
   logic [33:0] exp_q [$];
   logic [1:0] bexp_q [$];
   int fails = 0, cmp_count = 0, cyc = 0, k;
   tif_axi_regs u_dut (.*);
   tif_periph_model u_model (.clk_sys_i(CLK_SYS_I), .rst_b_i(RST_B_I), .fire_i(fire), .trap_o(TRAP_EVENT_I),
      .req_o(PERIPH_REQ_I), .pin_o(EXT_IRQ_PIN_I));
   initial begin
      forever #25 CLK_SYS_I = ~CLK_SYS_I;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [33:0] ok(input logic [15:0] d);
      return {RESP_OKAY, 16'h0000, d};
   endfunction
   task automatic end_of_test;
      $display("Comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp = RESP_OKAY);
      logic aw;
      logic w;
      bexp_q.push_back(resp);
      aw = 1;
      w = 1;
      S_AXI_AWADDR_I <= a;
      S_AXI_WDATA_I <= d;
      S_AXI_AWVALID_I <= 1;
      S_AXI_WVALID_I <= 1;
      while (aw || w) begin
         @(posedge CLK_SYS_I);
         if (aw && S_AXI_AWREADY_O) begin
            aw = 0;
            S_AXI_AWVALID_I <= 0;
         end
         if (w && S_AXI_WREADY_O) begin
            w = 0;
            S_AXI_WVALID_I <= 0;
         end
      end
      do @(posedge CLK_SYS_I); while (S_AXI_BVALID_O !== 1'b1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] exp);
      exp_q.push_back(exp);
      S_AXI_ARADDR_I <= a;
      S_AXI_ARVALID_I <= 1;
      do @(posedge CLK_SYS_I); while (S_AXI_ARREADY_O !== 1'b1);
      S_AXI_ARVALID_I <= 0;
      do @(posedge CLK_SYS_I); while (S_AXI_RVALID_O !== 1'b1);
   endtask
   task automatic pulse(input int n);
      fire <= 24'h1 << n;
      @(posedge CLK_SYS_I);
      fire <= '0;
      repeat (10) @(posedge CLK_SYS_I);
   endtask
   always @(posedge CLK_SYS_I) begin
      if (S_AXI_RVALID_O === 1'b1 && exp_q.size() > 0) begin
         chk({S_AXI_RRESP_O, S_AXI_RDATA_O}, exp_q.pop_front());
      end
      if (S_AXI_BVALID_O === 1'b1 && bexp_q.size() > 0) begin
         chk({32'h0, S_AXI_BRESP_O}, {32'h0, bexp_q.pop_front()});
      end
   end
   // The whole sequence needs under two thousand cycles, so this only catches a hang.
   always @(posedge CLK_SYS_I) begin
      cyc++;
      if (cyc == 6000) begin
         fails++;
         end_of_test();
      end
   end
   initial begin
      repeat (16) @(posedge CLK_SYS_I);
      RST_B_I <= 1'b1;
      @(posedge CLK_SYS_I);
      for (k = 0; k < 5; k++) rd(8'(k * 4), ok(RST_ZERO));
      rd(8'h14, {RESP_SLVERR, 32'h0});
      wr(8'h14, seed, RESP_SLVERR);
      wr(ADDR_VEC_EDGE, 32'hffffffff);
      rd(ADDR_VEC_EDGE, ok(VEC_RW_MASK));
      chk({33'h0, ALT_VECTOR_TABLE_SEL_O}, 34'h1);
      wr(ADDR_VEC_EDGE, 32'h0);
      IRQ_DISABLE_ACTIVE_ACTIVE_I <= 1'b1;
      repeat (6) @(posedge CLK_SYS_I);
      rd(ADDR_VEC_EDGE, ok(16'h4000));
      IRQ_DISABLE_ACTIVE_ACTIVE_I <= 1'b0;
      for (k = 0; k < 15; k++) begin
         pulse(k);
         rd(ADDR_FLAG0, ok(16'h1 << k));
         wr(ADDR_FLAG0, 32'h0);
         rd(ADDR_FLAG0, ok(RST_ZERO));
      end
      for (k = 0; k < 4; k++) begin
         pulse(15 + k);
         rd(ADDR_TRAP_CTL, ok(16'h10 >> k));
         wr(ADDR_TRAP_CTL, 32'h0);
      end
      rd(ADDR_TRAP_CTL, ok(RST_ZERO));
      seed = lfsr(seed);
      wr(ADDR_FLAG0_MASK, seed);
      rd(ADDR_FLAG0_MASK, ok(seed[15:0] & FLAG0_IMPL_MASK));
      k = seed[19:16] % 15;
      wr(ADDR_FLAG0_MASK, 32'hffff);
      pulse(k);
      chk({33'h0, IRQ_O}, 34'h1);
      wr(ADDR_FLAG0, 32'h0);
      repeat (3) @(posedge CLK_SYS_I);
      chk({33'h0, IRQ_O}, 34'h0);
      wr(ADDR_TRAP_MASK, 32'hffff);
      pulse(16);
      chk({33'h0, IRQ_O}, 34'h1);
      wr(ADDR_TRAP_CTL, 32'h0);
      wr(ADDR_FLAG0_MASK, 32'h0);
      pulse(k);
      chk({33'h0, IRQ_O}, 34'h0);
      wr(ADDR_FLAG0, 32'h0);
      pulse(19);
      rd(ADDR_FLAG0, ok(16'h0001));
      wr(ADDR_FLAG0, 32'h0);
      wr(ADDR_VEC_EDGE, 32'h1);
      pulse(19);
      rd(ADDR_FLAG0, ok(16'h0001));
      wr(ADDR_FLAG0, 32'h0);
      pulse(19);
      rd(ADDR_FLAG0, ok(RST_ZERO));
      RST_B_I <= 1'b0;
      @(posedge CLK_SYS_I);
      RST_B_I <= 1'b1;
      @(posedge CLK_SYS_I);
      rd(ADDR_VEC_EDGE, ok(RST_ZERO));
      repeat (3) @(posedge CLK_SYS_I);
      end_of_test();
   end
endmodule
